// [design/lmm_consts.svh]
// offsets, field positions, reset values and status bits of the mmu
// assumes inclusion by bare name ahead of the package and modules
//
// What this block does
// - map 16-bit logical to 20-bit physical
// - translate combinationally, no added cycles
// - three regions, 4 KB boundaries
// - lower common maps from physical zero
// - bank and upper common relocatable, 4 KB
// - overlapping physical images are never blocked
// - every memory cycle kind is translated
// - io address passes unchanged to low lines
// - io cycles force top nibble zero
// - dma owner drives full physical bus
// - boundary bits 7..4 start upper common
// - boundary bits 3..0 start bank region
// - upper common base relocates upper common
// - upper common base resets to zero
// - bank base relocates bank, resets zero
// - add 8-bit base to top nibble
// - reset gives identity map of 64 KB
// - register writes act from next cycle
`ifndef LMM_CONSTS_SVH
`define LMM_CONSTS_SVH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define LMM_IDX_UPPER_BASE 8'h38
`define LMM_IDX_BANK_BASE 8'h39
`define LMM_IDX_AREA_BOUND 8'h3a
`define LMM_IDX_STATUS 8'h3b
`define LMM_IDX_LAST_XLAT 8'h3c

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define LMM_UC_START_HI 7
`define LMM_UC_START_LO 4
`define LMM_BANK_START_HI 3
`define LMM_BANK_START_LO 0
`define LMM_RST_AREA_BOUND 8'hf0
`define LMM_RST_UPPER_BASE 8'h00
`define LMM_RST_BANK_BASE 8'h00
`define LMM_STAT_ORDER_ERR 0
`define LMM_STAT_OVERLAP 1

`endif

// [design/lmm_pkg.sv]
// types shared by the mmu modules
// assumes nothing beyond a systemverilog compiler
package lmm_pkg;

	// ----------------------------------------------------------------
	// cycle kinds, regions, bus slave states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {LMM_CYC_IDLE, LMM_CYC_MEM, LMM_CYC_IO} lmm_cyc_e;
	typedef enum logic [1:0] {LMM_REG_LOWER, LMM_REG_BANK, LMM_REG_UPPER,
		LMM_REG_NONE} lmm_region_e;
	typedef enum logic {LMM_BUS_IDLE, LMM_BUS_ACK} lmm_bus_e;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		lmm_cyc_e kind;
		logic [15:0] addr;
	} lmm_cycle_s;

	typedef struct packed {
		lmm_region_e region;
		logic [19:0] addr;
	} lmm_phys_s;

endpackage

// [design/lmm_map_reg.sv]
// one byte-wide mapping register with a fixed reset value
// assumes the write strobe is a single-cycle pulse on sys_clk
`timescale 1ns/100ps
`include "lmm_consts.svh"
module lmm_map_reg
	import lmm_pkg::*;
#(
	parameter logic [7:0] RESET_VALUE = 8'h00
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// write side
	input wire logic wrEn,
	input wire logic [7:0] wrData,
	// held value
	output logic [7:0] value
);

	logic [7:0] value_r;

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			value_r <= RESET_VALUE;
		else if (wrEn)
			value_r <= wrData;
	assign value = value_r;

endmodule // lmm_map_reg

// [design/lmm_region_sel.sv]
// classifies a logical page against the two programmed boundaries
// assumes upper start not below bank start; otherwise lower wins
`timescale 1ns/100ps
`include "lmm_consts.svh"
module lmm_region_sel
	import lmm_pkg::*;
(
	// logical page and boundaries
	input wire logic [3:0] page,
	input wire logic [3:0] upperStart,
	input wire logic [3:0] bankStart,
	// classification
	output lmm_region_e region
);

	wire isLower;
	wire isUpper;

	assign isLower = page < bankStart;
	assign isUpper = page >= upperStart;
	// lower is checked first so a bad setting still gives one answer
	assign region = isLower ? LMM_REG_LOWER :
		isUpper ? LMM_REG_UPPER : LMM_REG_BANK;

endmodule // lmm_region_sel

// [design/lmm_mmu.sv]
// logical to physical address translation with avalon register slave
// assumes cpu cycle and dma inputs come from logic on sys_clk
`timescale 1ns/100ps
`include "lmm_consts.svh"
module logical_to_physical_mmu
	import lmm_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// avalon-mm register slave
	input wire logic [9:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWritedata,
	input wire logic [3:0] avsByteenable,
	output logic [31:0] avsReaddata,
	output logic avsWaitrequest,
	// cpu side logical cycle
	input wire lmm_cycle_s cpuCycle,
	// on-chip dma controller bus ownership
	input wire logic dmaOwnsBus,
	input wire logic [19:0] dmaAddr,
	// external physical address
	output lmm_phys_s physOut
);

	// ----------------------------------------------------------------
	// bus slave state
	// ----------------------------------------------------------------
	lmm_bus_e busState_r;
	lmm_bus_e busState_nxt;
	logic [31:0] rdData_r;
	logic [31:0] rdData_nxt;

	wire busReq;
	wire [7:0] regIdx;
	wire accept;
	wire wrAccept;
	wire lowLane;

	assign busReq = avsRead | avsWrite;
	assign regIdx = avsAddress[9:2];
	// one wait state: data is prepared while waitrequest is high
	assign avsWaitrequest = busReq & (busState_r != LMM_BUS_ACK);
	assign accept = busReq & (busState_r == LMM_BUS_ACK);
	assign wrAccept = accept & avsWrite;
	assign lowLane = avsByteenable[0];

	always_comb
	begin
		busState_nxt = busState_r;
		case (busState_r)
			LMM_BUS_IDLE:
				if (busReq)
					busState_nxt = LMM_BUS_ACK;
			LMM_BUS_ACK:
				busState_nxt = LMM_BUS_IDLE;
			default:
				busState_nxt = LMM_BUS_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			busState_r <= LMM_BUS_IDLE;
		else
			busState_r <= busState_nxt;

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	wire hitUpperBase;
	wire hitBankBase;
	wire hitAreaBound;
	wire hitStatus;
	wire hitLast;
	wire wrUpperBase;
	wire wrBankBase;
	wire wrAreaBound;
	wire wrStatus;

	assign hitUpperBase = regIdx == `LMM_IDX_UPPER_BASE;
	assign hitBankBase = regIdx == `LMM_IDX_BANK_BASE;
	assign hitAreaBound = regIdx == `LMM_IDX_AREA_BOUND;
	assign hitStatus = regIdx == `LMM_IDX_STATUS;
	assign hitLast = regIdx == `LMM_IDX_LAST_XLAT;
	assign wrUpperBase = wrAccept & lowLane & hitUpperBase;
	assign wrBankBase = wrAccept & lowLane & hitBankBase;
	assign wrAreaBound = wrAccept & lowLane & hitAreaBound;
	assign wrStatus = wrAccept & lowLane & hitStatus;

	// ----------------------------------------------------------------
	// mapping registers
	// ----------------------------------------------------------------
	logic [7:0] upperCommonBase;
	logic [7:0] bankRegionBase;
	logic [7:0] areaBoundary;

	lmm_map_reg #(
		.RESET_VALUE(`LMM_RST_UPPER_BASE)
	) u_upper_common_base (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wrEn(wrUpperBase),
		.wrData(avsWritedata[7:0]),
		.value(upperCommonBase)
	);

	lmm_map_reg #(
		.RESET_VALUE(`LMM_RST_BANK_BASE)
	) u_bank_region_base (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wrEn(wrBankBase),
		.wrData(avsWritedata[7:0]),
		.value(bankRegionBase)
	);

	lmm_map_reg #(
		.RESET_VALUE(`LMM_RST_AREA_BOUND)
	) u_area_boundary (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wrEn(wrAreaBound),
		.wrData(avsWritedata[7:0]),
		.value(areaBoundary)
	);

	wire [3:0] upperCommonStart;
	wire [3:0] bankStart;

	assign upperCommonStart =
		areaBoundary[`LMM_UC_START_HI:`LMM_UC_START_LO];
	assign bankStart =
		areaBoundary[`LMM_BANK_START_HI:`LMM_BANK_START_LO];

	// ----------------------------------------------------------------
	// region select and page add
	// ----------------------------------------------------------------
	lmm_region_e memRegion;
	wire [3:0] logPage;
	wire [7:0] regionBase;
	wire [7:0] physPage;
	wire [19:0] memPhys;
	wire [19:0] ioPhys;

	assign logPage = cpuCycle.addr[15:12];

	lmm_region_sel u_region_sel (
		.page(logPage),
		.upperStart(upperCommonStart),
		.bankStart(bankStart),
		.region(memRegion)
	);

	// lower common has no base of its own
	assign regionBase = (memRegion == LMM_REG_UPPER) ? upperCommonBase :
		(memRegion == LMM_REG_BANK) ? bankRegionBase :
		8'h00;
	// eight-bit sum, any carry past a19 is lost
	assign physPage = regionBase + {4'h0, logPage};
	assign memPhys = {physPage, cpuCycle.addr[11:0]};
	assign ioPhys = {4'h0, cpuCycle.addr};

	// ----------------------------------------------------------------
	// physical bus drive
	// ----------------------------------------------------------------
	// combinational so the mapped address is ready in the same cycle
	wire isMem;
	wire isIo;

	assign isMem = cpuCycle.kind == LMM_CYC_MEM;
	assign isIo = cpuCycle.kind == LMM_CYC_IO;

	wire [19:0] physAddr;
	lmm_region_e physRegion;

	assign physAddr = dmaOwnsBus ? dmaAddr :
		isMem ? memPhys :
		isIo ? ioPhys : 20'h00000;
	assign physRegion = (!dmaOwnsBus && isMem) ? memRegion :
		LMM_REG_NONE;
	// one driver for the whole carrier keeps the output single-sourced
	assign physOut = '{region: physRegion, addr: physAddr};

	// ----------------------------------------------------------------
	// overlap watch
	// ----------------------------------------------------------------
	// overlap is only reported, never blocked; pages held in nine bits
	function automatic logic spanMeet(input logic [8:0] aLo,
		input logic [8:0] aHi, input logic [8:0] bLo, input logic [8:0] bHi);
		spanMeet = (aLo <= bHi) && (bLo <= aHi);
	endfunction

	wire lowerExists;
	wire bankExists;
	wire [8:0] lowerHi;
	wire [8:0] bankLo;
	wire [8:0] bankHi;
	wire [8:0] upperLo;
	wire [8:0] upperHi;
	wire overlapNow;

	assign lowerExists = bankStart != 4'h0;
	assign bankExists = upperCommonStart > bankStart;
	assign lowerHi = {5'h00, bankStart} - 9'h001;
	assign bankLo = {1'b0, bankRegionBase} + {5'h00, bankStart};
	assign bankHi = {1'b0, bankRegionBase} + {5'h00, upperCommonStart}
		- 9'h001;
	assign upperLo = {1'b0, upperCommonBase} + {5'h00, upperCommonStart};
	assign upperHi = {1'b0, upperCommonBase} + 9'h00f;
	assign overlapNow =
		(lowerExists && bankExists &&
			spanMeet(9'h000, lowerHi, bankLo, bankHi)) ||
		(lowerExists && spanMeet(9'h000, lowerHi, upperLo, upperHi)) ||
		(bankExists && spanMeet(bankLo, bankHi, upperLo, upperHi));

	// ----------------------------------------------------------------
	// boundary order flag
	// ----------------------------------------------------------------
	logic orderErr_r;
	logic orderErr_nxt;
	wire orderErrSet;
	wire orderErrClr;

	assign orderErrSet = wrAreaBound &&
		(avsWritedata[`LMM_UC_START_HI:`LMM_UC_START_LO] <
		avsWritedata[`LMM_BANK_START_HI:`LMM_BANK_START_LO]);
	assign orderErrClr = wrStatus & avsWritedata[`LMM_STAT_ORDER_ERR];

	// a set in the clearing cycle is kept
	always_comb
	begin
		orderErr_nxt = orderErr_r;
		if (orderErrClr)
			orderErr_nxt = 1'b0;
		if (orderErrSet)
			orderErr_nxt = 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			orderErr_r <= 1'b0;
		else
			orderErr_r <= orderErr_nxt;

	// ----------------------------------------------------------------
	// last translated memory cycle
	// ----------------------------------------------------------------
	logic [19:0] lastPhys_r;
	logic [1:0] lastRegion_r;
	wire captureMem;

	assign captureMem = isMem & ~dmaOwnsBus;

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
		begin
			lastPhys_r <= 20'h00000;
			lastRegion_r <= 2'h0;
		end
		else if (captureMem)
		begin
			lastPhys_r <= memPhys;
			lastRegion_r <= memRegion;
		end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	wire [31:0] statusWord;
	wire [31:0] lastWord;
	wire [31:0] readSel;
	wire readLoad;

	assign statusWord = {30'h00000000, overlapNow, orderErr_r};
	assign lastWord = {10'h000, lastRegion_r, lastPhys_r};
	// unmapped indices read as zero and ignore writes
	assign readSel = hitUpperBase ? {24'h000000, upperCommonBase} :
		hitBankBase ? {24'h000000, bankRegionBase} :
		hitAreaBound ? {24'h000000, areaBoundary} :
		hitStatus ? statusWord :
		hitLast ? lastWord : 32'h00000000;
	assign readLoad = avsRead & (busState_r == LMM_BUS_IDLE);

	always_comb
	begin
		rdData_nxt = rdData_r;
		if (readLoad)
			rdData_nxt = readSel;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			rdData_r <= 32'h00000000;
		else
			rdData_r <= rdData_nxt;

	assign avsReaddata = rdData_r;

endmodule // logical_to_physical_mmu

// [verif/lmm_chk.sv]
// concurrent checks on the mmu top ports, bound into the design
// assumes one clock domain with an asynchronous active-low reset
`timescale 1ns/100ps
module lmm_chk
	import lmm_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// register bus
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsReaddata,
	input wire logic avsWaitrequest,
	// cycles and physical address
	input wire lmm_cycle_s cpuCycle,
	input wire logic dmaOwnsBus,
	input wire logic [19:0] dmaAddr,
	input wire lmm_phys_s physOut
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire logic memCyc = cpuCycle.kind == LMM_CYC_MEM && !dmaOwnsBus;
	sequence s_req_waiting;
		(avsRead || avsWrite) && avsWaitrequest;
	endsequence
	sequence s_read_done;
		avsRead && !avsWaitrequest;
	endsequence
	a_one_wait: assert property (s_req_waiting |=> !avsWaitrequest)
		else $error("request waited more than one cycle");
	a_idle_nowait: assert property (!(avsRead || avsWrite) |->
		!avsWaitrequest) else $error("waitrequest high without request");
	a_read_holds: assert property (s_read_done |=> $stable(avsReaddata))
		else $error("read data moved after the answer");
	a_dma_bypass: assert property (dmaOwnsBus |->
		physOut.addr == dmaAddr && physOut.region == LMM_REG_NONE)
		else $error("dma address not passed through");
	a_io_pass: assert property (cpuCycle.kind == LMM_CYC_IO &&
		!dmaOwnsBus |-> physOut.addr == {4'h0, cpuCycle.addr})
		else $error("io address altered");
	a_offset_kept: assert property (memCyc |->
		physOut.addr[11:0] == cpuCycle.addr[11:0])
		else $error("page offset altered");
	a_region_set: assert property (memCyc |->
		physOut.region != LMM_REG_NONE) else $error("memory cycle unclassified");
	a_lower_zero: assert property (memCyc &&
		physOut.region == LMM_REG_LOWER |-> physOut.addr == {4'h0, cpuCycle.addr})
		else $error("lower common relocated");
endmodule // lmm_chk

bind logical_to_physical_mmu lmm_chk u_chk (.sys_clk, .rst_n, .avsRead,
	.avsWrite, .avsReaddata, .avsWaitrequest, .cpuCycle, .dmaOwnsBus,
	.dmaAddr, .physOut);

// [verif/lmm_cpu_model.sv]
// cpu core stand-in presenting logical cycles to the mmu
// assumes the bench changes its request just after a rising edge
`timescale 1ns/100ps
module lmm_cpu_model
	import lmm_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// requested cycle
	input wire logic reqValid,
	input wire lmm_cycle_s reqCycle,
	// cycle seen by the mmu
	output lmm_cycle_s cpuCycle
);
	// ----------------------------------------------------------------
	// idle churn
	// ----------------------------------------------------------------
	logic [15:0] junk_r;
	// idle address changes every cycle so no stale value looks live
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			junk_r <= 16'h5a5a;
		else
			junk_r <= ~junk_r;
	// fetches, data and vector cycles all arrive as one memory kind
	assign cpuCycle = reqValid ? reqCycle :
		'{kind: LMM_CYC_IDLE, addr: junk_r};
endmodule // lmm_cpu_model

// [verif/logical_to_physical_mmu_bench.sv]
// self-checking bench for the logical to physical mmu
// assumes the package, checker and cpu stand-in compile first
`timescale 1ns/100ps
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin \
err_total++; $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module logical_to_physical_mmu_bench
	import lmm_pkg::*;
;
	// ----------------------------------------------------------------
	// signals and rows
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ab, ub, bb;
		logic [15:0] la;
		logic [19:0] pa;
		lmm_region_e rg;
	} lmm_row_s;
	// boundary, upper base, bank base, logical, physical, region
	lmm_row_s rows [9] = '{
		'{8'hf0, 8'h00, 8'h00, 16'h1234, 20'h01234, LMM_REG_BANK},
		'{8'hc4, 8'h80, 8'h20, 16'h3abc, 20'h03abc, LMM_REG_LOWER},
		'{8'hc4, 8'h80, 8'h20, 16'h4001, 20'h24001, LMM_REG_BANK},
		'{8'hc4, 8'h80, 8'h20, 16'hbfff, 20'h2bfff, LMM_REG_BANK},
		'{8'hc4, 8'h80, 8'h20, 16'hc000, 20'h8c000, LMM_REG_UPPER},
		'{8'h84, 8'hff, 8'hf8, 16'hf123, 20'h0e123, LMM_REG_UPPER},
		'{8'h84, 8'hff, 8'hf8, 16'h7000, 20'hff000, LMM_REG_BANK},
		'{8'h44, 8'h10, 8'h10, 16'h4000, 20'h14000, LMM_REG_UPPER},
		'{8'hc4, 8'h00, 8'h08, 16'h4000, 20'h0c000, LMM_REG_BANK}};
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [9:0] avsAddress = 10'h000;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWritedata = 32'h0;
	logic [31:0] avsReaddata;
	logic [3:0] avsByteenable = 4'hf;
	logic avsWaitrequest;
	logic reqValid = 1'b0;
	logic dmaOwnsBus = 1'b0;
	logic [19:0] dmaAddr = 20'h0;
	lmm_cycle_s reqCycle = 18'h0;
	lmm_cycle_s cpuCycle;
	lmm_phys_s physOut;
	logic [31:0] rd;
	int err_total = 0;
	int num_checks = 0;

	always #10 sys_clk = ~sys_clk;

	logical_to_physical_mmu u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
		.avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
		.avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
		.cpuCycle(cpuCycle), .dmaOwnsBus(dmaOwnsBus), .dmaAddr(dmaAddr),
		.physOut(physOut));
	lmm_cpu_model u_cpu (.sys_clk(sys_clk), .rst_n(rst_n),
		.reqValid(reqValid), .reqCycle(reqCycle), .cpuCycle(cpuCycle));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task conclude;
		$display("mismatches %0d comparisons %0d", err_total, num_checks);
		if (err_total == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// one avalon access; starts a cycle after any release to avoid clashes
	// waitrequest is sampled at rising edges only; the watchdog ends a hang
	task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge sys_clk);
		avsAddress <= {idx, 2'b00};
		avsWrite <= wr;
		avsRead <= ~wr;
		avsWritedata <= {24'h000000, wd};
		@(posedge sys_clk);
		while (avsWaitrequest !== 1'b0)
			@(posedge sys_clk);
		rd = avsReaddata;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial
	begin
		#100000;
		err_total++;
		conclude();
	end

	initial
	begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			bus(1'b0, 8'h38 + i[7:0], 8'h00);
			`CHK("reset", (i == 2) ? 8'hf0 : 8'h00, rd)
		end
		bus(1'b1, 8'h10, 8'hff);
		bus(1'b0, 8'h10, 8'h00);
		`CHK("unmapped", 8'h00, rd)
		foreach (rows[i])
		begin
			bus(1'b1, 8'h38, rows[i].ub);
			bus(1'b1, 8'h39, rows[i].bb);
			bus(1'b1, 8'h3a, rows[i].ab);
			// checked in the first cycle after the write is taken
			reqCycle <= '{kind: LMM_CYC_MEM, addr: rows[i].la};
			reqValid <= 1'b1;
			@(negedge sys_clk);
			`CHK("phys", rows[i].pa, physOut.addr)
			`CHK("region", rows[i].rg, physOut.region)
			@(posedge sys_clk);
			reqCycle.kind <= LMM_CYC_IO;
			@(negedge sys_clk);
			`CHK("io", {4'h0, rows[i].la}, physOut.addr)
			@(posedge sys_clk);
			dmaOwnsBus <= 1'b1;
			dmaAddr <= ~rows[i].pa;
			@(negedge sys_clk);
			`CHK("dma", ~rows[i].pa, physOut.addr)
			@(posedge sys_clk);
			dmaOwnsBus <= 1'b0;
			reqValid <= 1'b0;
		end
		bus(1'b0, 8'h3c, 8'h00);
		`CHK("last", {10'h000, rows[8].rg, rows[8].pa}, rd)
		bus(1'b0, 8'h3b, 8'h00);
		`CHK("status", 32'h00000002, rd)
		avsByteenable <= 4'he;
		bus(1'b1, 8'h39, 8'h77);
		avsByteenable <= 4'hf;
		bus(1'b0, 8'h39, 8'h00);
		`CHK("bank lane", 8'h08, rd)
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		bus(1'b0, 8'h3a, 8'h00);
		`CHK("rereset", 8'hf0, rd)
		bus(1'b0, 8'h39, 8'h00);
		`CHK("rereset bank", 8'h00, rd)
		conclude();
	end
endmodule // logical_to_physical_mmu_bench
